// ==== hw/cix_pkg.sv ====
// Opcodes, flag layout and cycle counts for the instruction group executor
package cix_pkg;
  localparam logic [15:0] OP_BREAK = 16'h0001;
  localparam logic [15:0] OP_BREAKX = 16'h0005;
  localparam logic [7:0] OP_ANDI_HI = 8'h7E;
  localparam logic [7:0] OP_CMPI_HI = 8'h79;
  localparam logic [6:0] OP_CLR_HI = 7'h03;
  localparam logic [6:0] OP_CMPR_HI = 7'h02;
  localparam logic [6:0] OP_CSE_HI = 7'h21;
  localparam logic [3:0] OP_CLRB_HI = 4'h8;
  localparam logic [2:0] OP_CALL_HI = 3'h6;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_ZERO = 2;
  localparam int PAGE_LO = 5;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] CYC_SKIP = 2'h2;
  localparam logic [1:0] CYC_BREAKX = 2'h2;
  localparam logic [1:0] CYC_CALL = 2'h3;

  typedef struct packed {
    logic [15:0] word;
    logic [15:0] nextPc;
    logic valid;
  } cix_fetch_type;

  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] data;
  } cix_wr_type;

  typedef struct packed {
    logic push;
    logic pop;
    logic [15:0] data;
  } cix_stack_type;
endpackage

// ==== hw/cix_alu.sv ====
// Subtract/compare unit producing difference, carry, nibble borrow and zero
`timescale 1ns/1ns
module cix_alu
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic noBorrow,
  output logic nibbleNoBorrow,
  output logic isZero
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb
  begin
    full = {1'b0, minuend} - {1'b0, subtrahend};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    diff = full[7:0];
    noBorrow = ~full[8];
    nibbleNoBorrow = ~low[4];
    isZero = (full[7:0] == 8'h00);
  end
endmodule

// ==== hw/cix_exec.sv ====
// Execute unit for the AND/break/call/clear/compare/skip instruction group
//
// Function
// [RULE1] AND immediate into accumulator; zero flag reflects result.
// [RULE2] Debug halt flushes pipeline, stops progress, flags untouched.
// [RULE3] Halt released only by reset or debug port command.
// [RULE4] Halt-with-skip halts too, extends pending skip, takes two cycles; code enters halt after one cycle like break, CYC_BREAKX unused.
// [RULE5] Software puts halt-with-skip only after a bit-test skip.
// [RULE6] Call pushes full 16-bit next address onto return stack.
// [RULE7] Call target: low 13 bits from opcode, top 3 from page bits.
// [RULE8] Return pops saved address into program counter.
// [RULE9] Call takes three cycles including pipeline refill.
// [RULE10] Clear writes zero to register and sets zero flag.
// [RULE11] Bit clear touches one selected bit, no flags change.
// [RULE12] Register compare updates flags only, operands unchanged.
// [RULE13] Immediate compare updates flags only, accumulator unchanged.
// [RULE14] Carry flag cleared when accumulator exceeds operand, else set.
// [RULE15] Nibble flag cleared on nibble borrow; zero flag when difference zero.
// [RULE16] Equal-skip compares, changes nothing, skips next when equal.
// [RULE17] Skip instructions take one cycle, or two when skipping.
`timescale 1ns/1ns
module cix_exec
  import cix_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire cix_pkg::cix_fetch_type fetch,
  input wire logic [7:0] fileRdData,
  input wire logic retReq,
  input wire logic [15:0] stackTop,
  input wire logic debugResume,
  input wire logic loadWe,
  input wire logic [7:0] loadAcc,
  input wire logic [2:0] loadPage,
  output cix_pkg::cix_wr_type fileWr,
  output cix_pkg::cix_stack_type stackOp,
  output logic [7:0] acc,
  output logic [7:0] flags,
  output logic [15:0] pc,
  output logic halted,
  output logic busy,
  output logic flush
);
  import cix_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_SKIP = 2'b10,
    ST_HALT = 2'b11
  } cix_state_type;

  logic resumeMeta_r;
  logic resumeSync_r;
  cix_state_type state_r, state_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [15:0] pc_r, pc_nxt;
  cix_wr_type wr_r, wr_nxt;
  cix_stack_type stk_r, stk_nxt;
  logic flush_r, flush_nxt;
  logic halted_r, halted_nxt, busy_r, busy_nxt;
  logic [7:0] cmpA;
  logic [7:0] cmpDiff;
  logic cmpC;
  logic cmpDc;
  logic cmpZ;
  logic [15:0] w;
  logic isCmpI;
  logic isCmpR;
  logic isCse;

  assign w = fetch.word;
  assign isCmpI = (w[15:8] == OP_CMPI_HI);
  assign isCmpR = (w[15:9] == OP_CMPR_HI);
  assign isCse = (w[15:9] == OP_CSE_HI);
  assign cmpA = isCmpI ? w[7:0] : fileRdData;

  cix_alu u_alu
  (
    .minuend(cmpA),
    .subtrahend(acc_r),
    .diff(cmpDiff),
    .noBorrow(cmpC),
    .nibbleNoBorrow(cmpDc),
    .isZero(cmpZ)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode and execute
  always_comb
  begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    pc_nxt = pc_r;
    wr_nxt = '0;
    stk_nxt = '0;
    flush_nxt = 1'b0;
    unique case (state_r)
      ST_HALT:
      begin
        if (resumeSync_r) // RULE3
        begin
          state_nxt = ST_RUN;
          flush_nxt = 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (wait_r <= 2'd1)
        begin
          state_nxt = ST_RUN;
        end
        wait_nxt = wait_r - 2'd1;
      end
      ST_SKIP:
      begin
        state_nxt = ST_RUN; // RULE17
        pc_nxt = pc_r + 16'd1;
      end
      ST_RUN:
      begin
        if (retReq)
        begin
          pc_nxt = stackTop; // RULE8
          stk_nxt.pop = 1'b1;
          flush_nxt = 1'b1;
        end
        else if (fetch.valid)
        begin
          pc_nxt = fetch.nextPc;
          if (w[15:8] == OP_ANDI_HI)
          begin
            acc_nxt = acc_r & w[7:0]; // RULE1
            flags_nxt[FLAG_ZERO] = ((acc_r & w[7:0]) == 8'h00); // RULE1
          end
          else if (w == OP_BREAK)
          begin
            state_nxt = ST_HALT; // RULE2
            flush_nxt = 1'b1;
            pc_nxt = pc_r;
          end
          else if (w == OP_BREAKX)
          begin
            state_nxt = ST_HALT; // RULE4
            flush_nxt = 1'b1;
            pc_nxt = fetch.nextPc + 16'd1; // RULE4
          end
          else if (w[15:13] == OP_CALL_HI)
          begin
            stk_nxt.push = 1'b1; // RULE6
            stk_nxt.data = fetch.nextPc; // RULE6
            pc_nxt = {flags_r[PAGE_LO +: 3], w[12:0]}; // RULE7
            flush_nxt = 1'b1;
            state_nxt = ST_WAIT; // RULE9
            wait_nxt = CYC_CALL - 2'd1;
          end
          else if (w[15:9] == OP_CLR_HI)
          begin
            wr_nxt = '{we: 1'b1, addr: w[8:0], data: 8'h00}; // RULE10
            flags_nxt[FLAG_ZERO] = 1'b1; // RULE10
          end
          else if (w[15:12] == OP_CLRB_HI)
          begin
            wr_nxt = '{we: 1'b1, addr: w[8:0], data: fileRdData & ~(8'h01 << w[11:9])}; // RULE11
          end
          else if (isCmpR || isCmpI)
          begin
            flags_nxt[FLAG_CARRY] = cmpC; // RULE12 RULE13 RULE14
            flags_nxt[FLAG_NIBBLE] = cmpDc; // RULE15
            flags_nxt[FLAG_ZERO] = cmpZ; // RULE15
          end
          else if (isCse && cmpZ)
          begin
            state_nxt = ST_SKIP; // RULE16 RULE17
            flush_nxt = 1'b1;
          end
        end
        else if (loadWe)
        begin
          acc_nxt = loadAcc;
          flags_nxt[PAGE_LO +: 3] = loadPage;
        end
      end
    endcase
    halted_nxt = (state_nxt == ST_HALT);
    busy_nxt = (state_nxt != ST_RUN);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_RUN;
      wait_r <= 2'd0;
      acc_r <= ACC_RESET;
      flags_r <= FLAGS_RESET;
      pc_r <= PC_RESET;
      wr_r <= '0;
      stk_r <= '0;
      flush_r <= 1'b0;
      resumeMeta_r <= 1'b0;
      resumeSync_r <= 1'b0;
      halted_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      pc_r <= pc_nxt;
      wr_r <= wr_nxt;
      stk_r <= stk_nxt;
      flush_r <= flush_nxt;
      resumeMeta_r <= debugResume;
      resumeSync_r <= resumeMeta_r;
      halted_r <= halted_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign fileWr = wr_r;
  assign stackOp = stk_r;
  assign acc = acc_r;
  assign flags = flags_r;
  assign pc = pc_r;
  assign halted = halted_r;
  assign busy = busy_r;
  assign flush = flush_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_halt_hold;
    @(posedge clock) disable iff (!nrst)
    (state_r == ST_HALT && ce && !resumeSync_r) |=> state_r == ST_HALT && $stable(flags_r);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left"); // RULE2 RULE3
  property p_call;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && w[15:13] == OP_CALL_HI)
      |=> stk_r.push && stk_r.data == $past(fetch.nextPc) && pc_r[12:0] == $past(w[12:0]);
  endproperty
  a_call: assert property (p_call) else $error("call wrong"); // RULE6 RULE7
  property p_call_len;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && w[15:13] == OP_CALL_HI)
      |=> state_r == ST_WAIT && wait_r == CYC_CALL - 2'd1;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call wait not loaded"); // RULE9
  property p_call_end;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_WAIT && wait_r == 2'd1) |=> state_r == ST_RUN;
  endproperty
  a_call_end: assert property (p_call_end) else $error("call wait not ended"); // RULE9
  property p_and;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && w[15:8] == OP_ANDI_HI)
      |=> acc_r == ($past(acc_r) & $past(w[7:0])) && flags_r[FLAG_ZERO] == (acc_r == 8'h00);
  endproperty
  a_and: assert property (p_and) else $error("and wrong"); // RULE1
  property p_clr;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && w[15:9] == OP_CLR_HI)
      |=> wr_r.we && wr_r.data == 8'h00 && flags_r[FLAG_ZERO];
  endproperty
  a_clr: assert property (p_clr) else $error("clr wrong"); // RULE10
  property p_cmp;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && (isCmpR || isCmpI))
      |=> $stable(acc_r) && !wr_r.we && flags_r[FLAG_CARRY] == ($past(cmpA) >= $past(acc_r));
  endproperty
  a_cmp: assert property (p_cmp) else $error("cmp wrong"); // RULE12 RULE13 RULE14
  property p_cse;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && isCse)
      |=> $stable(flags_r) && $stable(acc_r) && ((state_r == ST_SKIP) == $past(cmpZ));
  endproperty
  a_cse: assert property (p_cse) else $error("cse wrong"); // RULE16 RULE17
  property p_clrb;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && !retReq && fetch.valid && w[15:12] == OP_CLRB_HI)
      |=> $stable(flags_r) && wr_r.data[$past(w[11:9])] == 1'b0;
  endproperty
  a_clrb: assert property (p_clrb) else $error("clrb wrong"); // RULE11
  property p_ret;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == ST_RUN && retReq) |=> pc_r == $past(stackTop) && stk_r.pop;
  endproperty
  a_ret: assert property (p_ret) else $error("ret wrong"); // RULE8
endmodule

// ==== sim/cix_exec_test.sv ====
// Self-checking bench for the instruction group executor
`timescale 1ns/1ns
module cix_exec_test;
  import cix_pkg::*;
  typedef struct {int due; int sel; logic [17:0] exp;} cix_note_type;
  logic clock, nrst, ce, retReq, debugResume, halted, busy, flush, loadWe;
  logic [7:0] fileRdData, acc, flags, ma, rd, k, loadAcc;
  logic [15:0] stackTop, pc, np;
  logic [2:0] mf, loadPage, pg;
  logic [8:0] a9;
  logic [12:0] off;
  cix_fetch_type fetch;
  cix_wr_type fileWr;
  cix_stack_type stackOp;
  cix_note_type notes[$];
  int cyc, miscompares, num_checks, seed;

  cix_exec DUT (.clock(clock), .nrst(nrst), .ce(ce), .fetch(fetch), .fileRdData(fileRdData),
    .retReq(retReq), .stackTop(stackTop), .debugResume(debugResume), .loadWe(loadWe),
    .loadAcc(loadAcc), .loadPage(loadPage), .fileWr(fileWr),
    .stackOp(stackOp), .acc(acc), .flags(flags), .pc(pc), .halted(halted), .busy(busy),
    .flush(flush));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(cix_note_type n);
    logic [17:0] got;
    case (n.sel)
      0: got = {10'h0, acc};
      1: got = {15'h0, flags[2:0]};
      2: got = fileWr;
      3: got = {2'h0, pc};
      4: got = stackOp;
      5: got = {17'h0, halted};
      6: got = {17'h0, busy};
      default: got = {17'h0, flush};
    endcase
    num_checks++;
    if (got !== n.exp)
    begin
      miscompares++;
      $display("wrong value at %0t: sel %0d expected %h got %h", $time, n.sel, n.exp, got);
    end
  endtask

  // Results fall due a set number of edges after the note
  always @(posedge clock)
  begin
    cyc++;
    for (int i = 0; i < notes.size(); i++)
    begin
      if (notes[i].due == cyc)
      begin
        check(notes[i]);
        notes.delete(i);
        i--;
      end
    end
  end

  task automatic note(int d, int s, logic [17:0] e);
    notes.push_back('{cyc + d, s, e});
  endtask

  task automatic issue(logic [15:0] w);
    @(posedge clock);
    fetch <= '{w, np, 1'b1};
    fileRdData <= rd;
    @(negedge clock);
  endtask

  // One-edge write-back into accumulator and page bits
  task automatic load(logic [7:0] a, logic [2:0] p);
    @(posedge clock);
    fetch.valid <= 1'b0;
    loadWe <= 1'b1;
    loadAcc <= a;
    loadPage <= p;
    @(posedge clock);
    loadWe <= 1'b0;
    @(negedge clock);
    ma = a;
    pg = p;
  endtask

  task automatic idle(int n);
    repeat (n)
    begin
      @(posedge clock);
      fetch.valid <= 1'b0;
    end
    @(negedge clock);
  endtask

  // Accumulator is always the subtrahend
  task automatic cmp(logic [7:0] op);
    mf = {op == ma, op[3:0] >= ma[3:0], op >= ma};
    note(2, 1, mf);
    note(2, 0, ma);
  endtask

  task automatic resume;
    @(posedge clock);
    debugResume <= 1'b1;
    @(negedge clock);
    note(5, 5, 0);
    repeat (5) @(posedge clock);
    debugResume <= 1'b0;
    @(negedge clock);
  endtask

  task automatic give_verdict;
    if (notes.size() != 0)
    begin
      miscompares++;
    end
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clock);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    seed = 83;
    nrst = 1'b0;
    ce = 1'b1;
    retReq = 1'b0;
    debugResume = 1'b0;
    loadWe = 1'b0;
    loadAcc = 8'h00;
    loadPage = 3'h0;
    pg = 3'h0;
    stackTop = 16'h0000;
    fetch = '0;
    fileRdData = 8'h00;
    {ma, mf, np, rd} = '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    note(1, 5, 0);
    for (int i = 0; i < 4; i++)
    begin
      load(8'($random(seed)), 3'($random(seed)));
      k = (i == 3) ? ~ma : 8'($random(seed));
      issue({8'h7E, k});
      ma = ma & k;
      mf[2] = (ma == 8'h00);
      note(2, 0, ma);
      note(2, 1, mf);
    end
    for (int i = 0; i < 6; i++)
    begin
      load(8'($random(seed)), pg);
      rd = (i == 0) ? 8'h00 : (i == 2) ? ma : 8'($random(seed));
      a9 = 9'($random(seed));
      issue({7'h02, a9});
      cmp(rd);
      k = (i == 1) ? 8'h00 : (i == 3) ? ma : 8'($random(seed));
      issue({8'h79, k});
      cmp(k);
    end
    // Frozen core must not take a presented instruction
    @(posedge clock);
    ce <= 1'b0;
    issue({8'h7E, 8'h00});
    note(2, 0, ma);
    note(3, 0, ma);
    @(posedge clock);
    ce <= 1'b1;
    fetch.valid <= 1'b0;
    @(negedge clock);
    rd = 8'($random(seed));
    a9 = 9'($random(seed));
    issue({7'h03, a9});
    mf[2] = 1'b1;
    note(2, 2, {1'b1, a9, 8'h00});
    note(2, 1, mf);
    for (int b = 0; b < 8; b++)
    begin
      rd = 8'($random(seed));
      issue({4'h8, b[2:0], a9});
      note(2, 2, {1'b1, a9, rd & ~(8'h01 << b)});
      note(2, 1, mf);
    end
    rd = ma;
    issue({7'h21, a9});
    note(2, 6, 1);
    note(2, 1, mf);
    note(3, 6, 0);
    idle(2);
    rd = ma ^ 8'h5A;
    issue({7'h21, a9});
    note(2, 6, 0);
    note(2, 0, ma);
    idle(1);
    np = 16'($random(seed));
    off = 13'($random(seed));
    issue({3'h6, off});
    note(2, 4, {2'b10, np});
    note(2, 3, {2'h0, pg, off});
    note(2, 7, 1);
    note(2, 6, 1);
    note(3, 6, 1);
    note(3, 4, 0);
    note(4, 6, 0);
    idle(3);
    @(posedge clock);
    retReq <= 1'b1;
    stackTop <= np;
    @(negedge clock);
    note(2, 3, {2'h0, np});
    @(posedge clock);
    retReq <= 1'b0;
    idle(2);
    issue(OP_BREAK);
    note(2, 5, 1);
    note(2, 1, mf);
    issue({8'h7E, 8'h00});
    note(2, 0, ma);
    note(2, 5, 1);
    idle(4);
    note(1, 5, 1);
    resume();
    issue(OP_BREAKX);
    note(2, 5, 1);
    note(2, 1, mf);
    idle(4);
    resume();
    idle(4);
    give_verdict();
  end
endmodule
